// ---- rtl/hopping_pkg.sv ----
package hopping_pkg;

   // Clock and pulse timing
   localparam int CLK_MHZ       = 100;
   localparam int TE_SLOW_US    = 400;
   localparam int TE_FAST_US    = 200;
   localparam int DEBOUNCE_MS   = 10;
   localparam int TE_SLOW_CYC   = TE_SLOW_US * CLK_MHZ;
   localparam int TE_FAST_CYC   = TE_FAST_US * CLK_MHZ;
   localparam int DEBOUNCE_CYC  = DEBOUNCE_MS * 1000 * CLK_MHZ;

   // Code word framing, in pulse elements
   localparam int PREAMBLE_TE   = 23;
   localparam int HEADER_TE     = 10;
   localparam int GUARD_TE      = 39;
   localparam int CODE_BITS     = 66;
   localparam int MIN_WORDS_ONE = 1;
   localparam int MIN_WORDS_SET = 4;
   localparam int FIFO_DEPTH    = 8;

   // Cipher
   localparam int          CIPHER_ROUNDS = 528;
   localparam logic [31:0] NLF_TABLE     = 32'h3A5C742E;

   // Parameter store layout
   localparam int         STORE_WORDS      = 12;
   localparam int         WORD_W           = 16;
   localparam logic [3:0] ADDR_KEY_A       = 4'h0;
   localparam logic [3:0] ADDR_KEY_B       = 4'h1;
   localparam logic [3:0] ADDR_KEY_C       = 4'h2;
   localparam logic [3:0] ADDR_KEY_D       = 4'h3;
   localparam logic [3:0] ADDR_ROLLING     = 4'h4;
   localparam logic [3:0] ADDR_SPARE       = 4'h5;
   localparam logic [3:0] ADDR_ID_LOW      = 4'h6;
   localparam logic [3:0] ADDR_ID_HIGH     = 4'h7;
   localparam logic [3:0] ADDR_LEARN_LOW   = 4'h8;
   localparam logic [3:0] ADDR_LEARN_HIGH  = 4'h9;
   localparam logic [3:0] ADDR_CHECK       = 4'hA;
   localparam logic [3:0] ADDR_OPTION      = 4'hB;
   localparam logic [15:0] STORE_RESET     = 16'h0000;

   // Option word fields
   localparam int OPT_TRIM_LSB = 0;
   localparam int OPT_TRIP     = 4;
   localparam int OPT_RATE     = 5;
   localparam int OPT_MIN4     = 6;
   localparam int OPT_START    = 7;
   localparam int OPT_FORCE    = 8;
   localparam int OPT_LONG     = 9;
   localparam int CHECK_MSB    = 11;
   localparam int SHORT_ID_W   = 28;

   // Pin synchroniser slots
   localparam int PIN_COUNT = 6;
   localparam int PIN_B0    = 0;
   localparam int PIN_B1    = 1;
   localparam int PIN_B2    = 2;
   localparam int PIN_DATA  = 3;
   localparam int PIN_LOWB  = 4;
   localparam int PIN_PROG  = 5;

   typedef enum logic [1:0] {TRIP_4V4, TRIP_9V0, TRIP_6V75} trip_code_t;

   // One queued code word
   typedef struct packed {
      logic                 lead_pulse;
      logic                 blank;
      logic [CODE_BITS-1:0] bits;
   } tx_word_t;

endpackage

// ---- rtl/code_hopping_encoder_core.sv ----
`timescale 1ns/10ps

// Word queue between code word assembly and the pulse-width serialiser
module word_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input  wire logic             clk_sys,
   input  wire logic             reset,
   input  wire logic             flush,
   // Fill side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0]    wr_q;
   logic [AW-1:0]    rd_q;
   logic [AW:0]      count_q;
   wire              push = in_valid & in_ready;
   wire              pop  = out_valid & out_ready;

   // Honest full and empty from the fill count
   assign in_ready  = (count_q != (AW+1)'(DEPTH));
   assign out_valid = (count_q != '0);
   assign out_data  = mem_q[rd_q];

   // Pointers and fill count
   always_ff @(posedge clk_sys or posedge reset)
   begin
      if (reset)
      begin
         wr_q    <= '0;
         rd_q    <= '0;
         count_q <= '0;
      end
      else if (flush)
      begin
         wr_q    <= '0;
         rd_q    <= '0;
         count_q <= '0;
      end
      else
      begin
         if (push) wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
         if (pop)  rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
         count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end

   // Storage
   always_ff @(posedge clk_sys)
   begin
      if (push) mem_q[wr_q] <= in_data;
   end
endmodule

// Nonlinear feedback block cipher, one round per clock
module hop_cipher
   import hopping_pkg::*;
(
   // Clock and reset
   input  wire logic        clk_sys,
   input  wire logic        reset,
   // Request
   input  wire logic        start,
   input  wire logic [31:0] plain,
   input  wire logic [63:0] key,
   // Answer
   output logic             done,
   output logic [31:0]      result
);
   logic [31:0] x_q;
   logic [63:0] k_q;
   logic [9:0]  round_q;
   logic        busy_q;
   logic        done_q;
   wire  [4:0]  nlf_idx = {x_q[31], x_q[26], x_q[20], x_q[9], x_q[1]};
   wire         fb      = NLF_TABLE[nlf_idx] ^ x_q[16] ^ x_q[0] ^ k_q[0];

   assign done   = done_q;
   assign result = x_q;

   // Round engine with start and done handshake
   always_ff @(posedge clk_sys or posedge reset)
   begin
      if (reset)
      begin
         x_q     <= '0;
         k_q     <= '0;
         round_q <= '0;
         busy_q  <= 1'b0;
         done_q  <= 1'b0;
      end
      else
      begin
         done_q <= 1'b0;
         if (start)
         begin
            x_q     <= plain;
            k_q     <= key;
            round_q <= '0;
            busy_q  <= 1'b1;
         end
         else if (busy_q)
         begin
            x_q     <= {fb, x_q[31:1]};
            k_q     <= {k_q[0], k_q[63:1]};
            round_q <= round_q + 1'b1;
            if (round_q == 10'(CIPHER_ROUNDS-1))
            begin
               busy_q <= 1'b0;
               done_q <= 1'b1;
            end
         end
      end
   end
endmodule

// Encoder control core
module code_hopping_encoder_core
   import hopping_pkg::*;
#(
   parameter int DEB_CYCLES  = DEBOUNCE_CYC,
   parameter int SLOW_CYCLES = TE_SLOW_CYC,
   parameter int FAST_CYCLES = TE_FAST_CYC
) (
   // Clock and reset
   input  wire logic       clk_sys,
   input  wire logic       reset,
   // Button pins
   input  wire logic       button_in_zero,
   input  wire logic       button_in_one,
   input  wire logic       button_in_two,
   // Data pin, two-way
   input  wire logic       data_in,
   output logic            data_out,
   output logic            data_oe,
   // Programming mode strap and battery detector
   input  wire logic       prog_mode,
   input  wire logic       low_battery_flag,
   // Analog controls and power state
   output logic [3:0]      osc_trim,
   output trip_code_t      trip_code,
   output logic            awake
);
   typedef enum {C_SLEEP, C_DEBOUNCE, C_CIPHER, C_SEND, C_DRAIN} ctl_state_t;
   typedef enum {S_IDLE, S_LEAD, S_PRE, S_HDR, S_BITS, S_GUARD} ser_state_t;

   // Pin synchronisers, a change counts once stages two and three agree
   wire  [PIN_COUNT-1:0] pin_raw = {prog_mode, low_battery_flag, data_in,
                                    button_in_two, button_in_one, button_in_zero};
   logic [PIN_COUNT-1:0] pin_clean;
   genvar gp;
   generate
      for (gp = 0; gp < PIN_COUNT; gp++)
      begin : g_pin
         logic s1_q, s2_q, s3_q, clean_q;
         always_ff @(posedge clk_sys or posedge reset)
         begin
            if (reset)
            begin
               {s1_q, s2_q, s3_q, clean_q} <= 4'h0;
            end
            else
            begin
               s1_q <= pin_raw[gp];
               s2_q <= s1_q;
               s3_q <= s2_q;
               if (s2_q == s3_q) clean_q <= s3_q;
            end
         end
         assign pin_clean[gp] = clean_q;
      end
   endgenerate

   wire [2:0] btn_now  = pin_clean[PIN_B2:PIN_B0];
   wire       btn_any  = |btn_now;
   wire       in_prog  = pin_clean[PIN_PROG];

   // Parameter store write port
   logic        wr_en;
   logic [3:0]  wr_addr;
   logic [15:0] wr_data;
   logic [15:0] store_q [STORE_WORDS];

   // Parameter store, twelve 16-bit words
   genvar gw;
   generate
      for (gw = 0; gw < STORE_WORDS; gw++)
      begin : g_store
         always_ff @(posedge clk_sys or posedge reset)
         begin
            if (reset)
               store_q[gw] <= STORE_RESET;
            else if (wr_en && wr_addr == 4'(gw))
               store_q[gw] <= wr_data;
         end
      end
   endgenerate

   // Store fields
   wire [63:0] key_full = {store_q[ADDR_KEY_D], store_q[ADDR_KEY_C],
                           store_q[ADDR_KEY_B], store_q[ADDR_KEY_A]};
   wire [15:0] rolling  = store_q[ADDR_ROLLING];
   wire [31:0] id_full  = {store_q[ADDR_ID_HIGH], store_q[ADDR_ID_LOW]};
   wire [31:0] learn    = {store_q[ADDR_LEARN_HIGH], store_q[ADDR_LEARN_LOW]};
   wire [11:0] check    = store_q[ADDR_CHECK][CHECK_MSB:0];
   wire [15:0] opt      = store_q[ADDR_OPTION];
   wire        rate_sel = opt[OPT_RATE];
   wire        min_four = opt[OPT_MIN4];
   wire        start_en = opt[OPT_START];
   wire        s_force  = opt[OPT_FORCE];
   wire        long_id  = opt[OPT_LONG];

   // Programming loader, third button clocks data pin bits in LSB first
   logic        prog_clk_prev_q;
   logic [15:0] prog_shift_q;
   logic [3:0]  prog_bit_q;
   logic [3:0]  prog_ptr_q;
   wire         prog_edge = in_prog & pin_clean[PIN_B2] & ~prog_clk_prev_q;
   wire [15:0]  prog_word = {pin_clean[PIN_DATA], prog_shift_q[15:1]};
   wire         prog_wr   = prog_edge & (prog_bit_q == 4'hF);

   always_ff @(posedge clk_sys or posedge reset)
   begin
      if (reset)
      begin
         prog_clk_prev_q <= 1'b0;
         prog_shift_q    <= '0;
         prog_bit_q      <= '0;
         prog_ptr_q      <= '0;
      end
      else
      begin
         prog_clk_prev_q <= pin_clean[PIN_B2];
         if (!in_prog)
         begin
            prog_bit_q <= '0;
            prog_ptr_q <= '0;
         end
         else if (prog_edge)
         begin
            prog_shift_q <= prog_word;
            prog_bit_q   <= prog_bit_q + 1'b1;
            if (prog_wr)
               prog_ptr_q <= (prog_ptr_q == ADDR_OPTION) ? ADDR_KEY_A : prog_ptr_q + 1'b1;
         end
      end
   end

   // Controller registers
   ctl_state_t  ctl_q;
   logic [19:0] deb_q;
   logic [2:0]  btn_q;
   logic        low_battery_flag_q;
   logic [31:0] hop_q;
   logic [2:0]  words_q;
   logic        blank_q;
   logic        cipher_go_q;
   logic        sync_wr_q;
   wire         cipher_done;
   wire [31:0]  cipher_out;

   // Code word assembly
   wire        seed_mode = &btn_q;
   wire        status_hi = s_force | btn_q[2];
   wire [3:0]  status    = {status_hi, btn_q[2], btn_q[1], btn_q[0]};
   wire [31:0] plain     = {status, check, rolling};
   wire [31:0] id_field  = long_id ? id_full
                         : {status, id_full[SHORT_ID_W-1:0]};
   wire        repeat_b  = (words_q != '0);
   tx_word_t   push_word;
   assign push_word.lead_pulse = start_en & (words_q == '0);
   assign push_word.blank      = rate_sel & blank_q;
   assign push_word.bits       = {repeat_b, low_battery_flag_q, id_field, hop_q};

   // Controller decode
   wire [2:0] min_words = min_four ? 3'(MIN_WORDS_SET) : 3'(MIN_WORDS_ONE);
   wire       new_press = (ctl_q == C_CIPHER || ctl_q == C_SEND || ctl_q == C_DRAIN)
                          && |(btn_now & ~btn_q);
   wire       fifo_in_ready;
   wire       fifo_out_valid;
   wire       need_more = (words_q < min_words) | (btn_any & ~fifo_out_valid);
   wire       push      = (ctl_q == C_SEND) & need_more & fifo_in_ready;
   wire       deb_done  = (deb_q == 20'(DEB_CYCLES-1));
   logic      ser_idle;

   // Store write arbitration, a programming write wins over counter writeback
   assign wr_en   = prog_wr | sync_wr_q;
   assign wr_addr = prog_wr ? prog_ptr_q : ADDR_ROLLING;
   assign wr_data = prog_wr ? prog_word : rolling + 16'h0001;

   // Controller sequence
   always_ff @(posedge clk_sys or posedge reset)
   begin
      if (reset)
      begin
         ctl_q       <= C_SLEEP;
         deb_q       <= '0;
         btn_q       <= '0;
         low_battery_flag_q      <= 1'b0;
         hop_q       <= '0;
         words_q     <= '0;
         blank_q     <= 1'b0;
         cipher_go_q <= 1'b0;
         sync_wr_q   <= 1'b0;
      end
      else
      begin
         cipher_go_q <= 1'b0;
         sync_wr_q   <= 1'b0;
         if (new_press)
         begin
            ctl_q <= C_DEBOUNCE;
            deb_q <= '0;
         end
         else
         begin
            case (ctl_q)
               C_SLEEP:
                  if (btn_any && !in_prog)
                  begin
                     ctl_q <= C_DEBOUNCE;
                     deb_q <= '0;
                  end
               C_DEBOUNCE:
                  if (deb_done)
                  begin
                     words_q <= '0;
                     blank_q <= 1'b0;
                     btn_q   <= btn_now;
                     low_battery_flag_q  <= pin_clean[PIN_LOWB];
                     if (btn_any)
                     begin
                        ctl_q       <= C_CIPHER;
                        cipher_go_q <= 1'b1;
                     end
                     else
                        ctl_q <= C_SLEEP;
                  end
                  else
                     deb_q <= deb_q + 1'b1;
               C_CIPHER:
                  if (cipher_done)
                  begin
                     hop_q     <= seed_mode ? learn : cipher_out;
                     sync_wr_q <= 1'b1;
                     ctl_q     <= C_SEND;
                  end
               C_SEND:
                  if (push)
                  begin
                     blank_q <= ~blank_q;
                     if (words_q != 3'(MIN_WORDS_SET)) words_q <= words_q + 1'b1;
                  end
                  else if (!need_more)
                     ctl_q <= C_DRAIN;
               C_DRAIN:
                  if (need_more)
                     ctl_q <= C_SEND;
                  else if (!fifo_out_valid && ser_idle)
                     ctl_q <= C_SLEEP;
               default:
                  ctl_q <= C_SLEEP;
            endcase
         end
      end
   end

   hop_cipher u_cipher (
      .clk_sys (clk_sys),
      .reset   (reset),
      .start   (cipher_go_q),
      .plain   (plain),
      .key     (key_full),
      .done    (cipher_done),
      .result  (cipher_out)
   );

   // Word queue toward the serialiser
   tx_word_t fifo_out;
   wire      ser_pop;
   word_fifo #(
      .WIDTH ($bits(tx_word_t)),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk_sys   (clk_sys),
      .reset     (reset),
      .flush     (new_press),
      .in_valid  (push),
      .in_ready  (fifo_in_ready),
      .in_data   (push_word),
      .out_valid (fifo_out_valid),
      .out_ready (ser_pop),
      .out_data  (fifo_out)
   );

   // Serialiser registers
   ser_state_t ser_q;
   tx_word_t   word_q;
   logic [15:0] te_cnt_q;
   logic [5:0]  unit_q;
   logic [6:0]  bit_q;
   logic [1:0]  slot_q;
   logic        data_q;
   logic        oe_q;
   logic [3:0]  trim_q;
   trip_code_t  trip_q;
   logic        awake_q;

   // Element divider, one-cycle tick per pulse element
   wire [15:0] te_last = rate_sel ? 16'(FAST_CYCLES-1) : 16'(SLOW_CYCLES-1);
   wire        te_tick = (ser_q != S_IDLE) & (te_cnt_q >= te_last);
   assign ser_idle = (ser_q == S_IDLE);
   assign ser_pop  = ser_idle & fifo_out_valid & ~new_press;

   // Pin level per phase: bit is high, then inverted data, then low
   wire cur_bit = word_q.bits[bit_q];
   logic level;
   always_comb
   begin
      case (ser_q)
         S_LEAD:  level = 1'b1;
         S_PRE:   level = ~unit_q[0];
         S_BITS:  level = (slot_q == 2'd0) | ((slot_q == 2'd1) & ~cur_bit);
         default: level = 1'b0;
      endcase
   end

   // Serialiser sequence
   always_ff @(posedge clk_sys or posedge reset)
   begin
      if (reset)
      begin
         ser_q    <= S_IDLE;
         word_q   <= '0;
         te_cnt_q <= '0;
         unit_q   <= '0;
         bit_q    <= '0;
         slot_q   <= '0;
      end
      else if (new_press)
         ser_q <= S_IDLE;
      else if (ser_pop)
      begin
         word_q   <= fifo_out;
         te_cnt_q <= '0;
         unit_q   <= '0;
         ser_q    <= fifo_out.lead_pulse ? S_LEAD : S_PRE;
      end
      else if (!ser_idle)
      begin
         te_cnt_q <= te_tick ? '0 : te_cnt_q + 1'b1;
         if (te_tick)
         begin
            unit_q <= unit_q + 1'b1;
            case (ser_q)
               S_LEAD:
               begin
                  ser_q  <= S_PRE;
                  unit_q <= '0;
               end
               S_PRE:
                  if (unit_q == 6'(PREAMBLE_TE-1))
                  begin
                     ser_q  <= S_HDR;
                     unit_q <= '0;
                  end
               S_HDR:
                  if (unit_q == 6'(HEADER_TE-1))
                  begin
                     ser_q  <= S_BITS;
                     bit_q  <= '0;
                     slot_q <= '0;
                  end
               S_BITS:
                  if (slot_q == 2'd2)
                  begin
                     slot_q <= '0;
                     bit_q  <= bit_q + 1'b1;
                     if (bit_q == 7'(CODE_BITS-1))
                     begin
                        ser_q  <= S_GUARD;
                        unit_q <= '0;
                     end
                  end
                  else
                     slot_q <= slot_q + 1'b1;
               S_GUARD:
                  if (unit_q == 6'(GUARD_TE-1))
                     ser_q <= S_IDLE;
               default:
                  ser_q <= S_IDLE;
            endcase
         end
      end
   end

   // Output flops: pin drive, trim, trip point, power state
   always_ff @(posedge clk_sys or posedge reset)
   begin
      if (reset)
      begin
         data_q  <= 1'b0;
         oe_q    <= 1'b0;
         trim_q  <= '0;
         trip_q  <= TRIP_4V4;
         awake_q <= 1'b0;
      end
      else
      begin
         data_q  <= level & ~word_q.blank & ~in_prog;
         oe_q    <= ~in_prog;
         trim_q  <= opt[OPT_TRIM_LSB +: 4];
         trip_q  <= !opt[OPT_TRIP] ? TRIP_4V4 : (s_force ? TRIP_6V75 : TRIP_9V0);
         awake_q <= (ctl_q != C_SLEEP);
      end
   end

   assign data_out  = data_q;
   assign data_oe   = oe_q;
   assign osc_trim  = trim_q;
   assign trip_code = trip_q;
   assign awake     = awake_q;
endmodule

// ---- bench/hopping_core_props.sv ----
`timescale 1ns/10ps
// Pin-level checks on the encoder core
module hopping_core_props
   import hopping_pkg::*;
#(
   parameter int DEB_CYCLES  = 50,
   parameter int FAST_CYCLES = 10
) (
   // Clock and reset
   input wire logic       clk_sys,
   input wire logic       reset,
   // Watched pins
   input wire logic       button_in_zero,
   input wire logic       prog_mode,
   input wire logic       data_out,
   input wire logic       data_oe,
   input wire logic [3:0] osc_trim,
   input wire logic [1:0] trip_code,
   input wire logic       awake
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);
   logic [31:0] wake_q;
   logic [31:0] high_q;
   // Cycles spent awake and cycles the pin has been high
   always_ff @(posedge clk_sys or posedge reset)
      if (reset)
      begin
         wake_q <= '0;
         high_q <= '0;
      end
      else
      begin
         wake_q <= awake ? wake_q + 32'h1 : 32'h0;
         high_q <= data_out ? high_q + 32'h1 : 32'h0;
      end
   a_wake_on_press: assert property ($rose(button_in_zero) && !awake && !prog_mode
      |-> ##[1:8] awake) else $error("no wake after press");
   a_debounce_first: assert property (data_out |-> wake_q > DEB_CYCLES)
      else $error("pin active inside debounce");
   a_prog_release: assert property ($rose(prog_mode) |-> ##[1:6] !data_oe)
      else $error("pin still driven in programming");
   a_undriven_low: assert property (!data_oe |-> !data_out)
      else $error("pin level while released");
   a_sleep_quiet: assert property (!awake |-> !data_out)
      else $error("pin active while asleep");
   a_trim_steady: assert property (awake |-> $stable(osc_trim))
      else $error("trim moved while awake");
   a_trip_steady: assert property (awake |-> $stable(trip_code) && trip_code != 2'h3)
      else $error("bad threshold code");
   a_pulse_width: assert property ($fell(data_out) |-> high_q % FAST_CYCLES == 0)
      else $error("high pulse not whole elements");
   c_wake: cover property ($rose(awake));
   c_pulse: cover property ($fell(data_out));
   c_prog: cover property ($rose(prog_mode));
endmodule
bind code_hopping_encoder_core hopping_core_props #(
   .DEB_CYCLES  (DEB_CYCLES),
   .FAST_CYCLES (FAST_CYCLES)
) props_u (
   .clk_sys        (clk_sys),
   .reset          (reset),
   .button_in_zero (button_in_zero),
   .prog_mode      (prog_mode),
   .data_out       (data_out),
   .data_oe        (data_oe),
   .osc_trim       (osc_trim),
   .trip_code      (trip_code),
   .awake          (awake)
);

// ---- bench/rf_word_receiver.sv ----
`timescale 1ns/10ps
// Pulse-width word receiver on the data pin
module rf_word_receiver (
   // Clock, reset, pin level and element length
   input  wire logic       clk_sys,
   input  wire logic       reset,
   input  wire logic       line_in,
   input  wire logic [7:0] te_cyc,
   // Last whole word and count of words
   output logic [65:0]     word_q,
   output logic [7:0]      count_q
);
   logic [15:0] high_q;
   logic [15:0] low_q;
   logic [6:0]  index_q;
   logic [65:0] shift_q;
   wire         gap_w = !line_in && low_q == 16'(te_cyc) * 16'h8;
   // Short high is a one, long high a zero, LSB first; long low ends a word
   always_ff @(posedge clk_sys or posedge reset)
      if (reset)
         {high_q, low_q, index_q, shift_q, word_q, count_q} <= '0;
      else
      begin
         high_q <= line_in ? high_q + 16'h1 : 16'h0;
         low_q <= line_in ? 16'h0 : low_q + 16'h1;
         if (!line_in && high_q != 16'h0)
         begin
            shift_q <= {(high_q * 16'h2 <= 16'(te_cyc) * 16'h3), shift_q[65:1]};
            index_q <= index_q + 7'h1;
         end
         if (gap_w)
            index_q <= 7'h0;
         if (gap_w && index_q == 7'h42)
         begin
            word_q <= shift_q;
            count_q <= count_q + 8'h1;
         end
      end
endmodule

// ---- bench/test_code_hopping_encoder_core.sv ----
`timescale 1ns/10ps
// Encoder core bench
module test_code_hopping_encoder_core
   import hopping_pkg::*;
;
   logic        clk_sys;
   logic        reset;
   logic        prog_mode;
   logic        low_bat;
   logic        pin_drv;
   logic [2:0]  btn;
   logic [7:0]  te;
   logic        data_out;
   logic        data_oe;
   logic        awake;
   logic [3:0]  osc_trim;
   trip_code_t  trip_code;
   logic [65:0] rx_word;
   logic [7:0]  rx_count;
   wire         pin = data_oe ? data_out : pin_drv;
   int          num_errors = 0;
   int          check_count = 0;
   logic [15:0] store [12] = '{16'h1A2B, 16'h3C4D, 16'h5E6F, 16'h7081, 16'h0000, 16'h0000,
                               16'h3C5A, 16'hE1B4, 16'h9D2F, 16'h47C1, 16'hF2A7, 16'h0000};
   // Clock
   initial
   begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   code_hopping_encoder_core #(
      .DEB_CYCLES  (50),
      .SLOW_CYCLES (20),
      .FAST_CYCLES (10)
   ) dut_u (
      .clk_sys          (clk_sys),
      .reset            (reset),
      .button_in_zero   (btn[0]),
      .button_in_one    (btn[1]),
      .button_in_two    (btn[2]),
      .data_in          (pin),
      .data_out         (data_out),
      .data_oe          (data_oe),
      .prog_mode        (prog_mode),
      .low_battery_flag (low_bat),
      .osc_trim         (osc_trim),
      .trip_code        (trip_code),
      .awake            (awake)
   );
   rf_word_receiver rx_u (
      .clk_sys (clk_sys),
      .reset   (reset),
      .line_in (pin),
      .te_cyc  (te),
      .word_q  (rx_word),
      .count_q (rx_count)
   );
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   task automatic chk(input logic [71:0] got, input logic [71:0] exp);
      check_count++;
      if (got !== exp)
      begin
         num_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic results();
      if (num_errors == 0 && check_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // Load twelve words LSB first, each bit clocked by the third button
   task automatic load_store(input logic [15:0] opt);
      store[11] = opt;
      prog_mode <= 1'b1;
      tick(6);
      for (int i = 0; i < 192; i++)
      begin
         pin_drv <= store[i / 16][i % 16];
         tick(2);
         btn[2] <= 1'b1;
         tick(5);
         btn[2] <= 1'b0;
         tick(5);
      end
      prog_mode <= 1'b0;
      tick(8);
   endtask
   // Press past the latch point, release, wait for sleep, count words
   task automatic press(input logic [2:0] keys, input int words);
      int n;
      n = rx_count;
      btn <= keys;
      tick(300);
      chk(72'(awake), 72'h1);
      btn <= 3'b000;
      for (int i = 0; i < 40000 && awake === 1'b1; i++)
         tick(1);
      tick(4);
      chk(72'(awake), 72'h0);
      chk(72'(8'(rx_count - n)), 72'(words));
   endtask
   // Learn value on all three buttons, short id, low battery
   task automatic seed_word();
      low_bat <= 1'b1;
      load_store(16'h0000);
      press(3'b111, 1);
      chk({rx_word, 2'(trip_code), osc_trim}, {2'b01, 4'hF, store[7][11:0], store[6],
          store[9], store[8], 2'(TRIP_4V4), 4'h0});
   endtask
   // Every option but fast rate: four words, long id, start pulse, forced status
   task automatic long_id();
      low_bat <= 1'b0;
      load_store(16'h03D5);
      press(3'b010, 4);
      chk({rx_word[65:32], 32'h0, 2'(trip_code), osc_trim},
          {2'b10, store[7], store[6], 32'h0, 2'(TRIP_6V75), 4'h5});
   endtask
   // Fast rate blanks every second word
   task automatic fast_rate();
      te <= 8'h0A;
      load_store(16'h0070);
      press(3'b001, 2);
      chk({rx_word[65:32], 32'h0, 2'(trip_code), osc_trim},
          {2'b10, 4'h1, store[7][11:0], store[6], 32'h0, 2'(TRIP_9V0), 4'h0});
   endtask
   // Second button joins during encryption, forced fourth status bit
   task automatic abort_press();
      load_store(16'h0170);
      btn <= 3'b001;
      tick(150);
      press(3'b011, 2);
      chk({rx_word[65:32], 32'h0, 2'(trip_code), osc_trim},
          {2'b10, 4'hB, store[7][11:0], store[6], 32'h0, 2'(TRIP_6V75), 4'h0});
   endtask
   // Main sequence
   initial
   begin
      reset = 1'b1;
      btn = 3'b000;
      prog_mode = 1'b0;
      low_bat = 1'b0;
      pin_drv = 1'b1;
      te = 8'h14;
      tick(8);
      reset <= 1'b0;
      tick(6);
      seed_word();
      long_id();
      fast_rate();
      abort_press();
      results();
   end
   // Watchdog
   initial
   begin
      #1000000;
      num_errors++;
      results();
   end
endmodule
